/* pkg/msbc_link_if.sv */
// edge connector pins between host board and module
`timescale 1ns/10ps
interface msbc_link_if (
    input wire logic mgmt_clock
);
    // host drives select, reset and power pins only while this is high
    logic host_drive_en;
    logic host_select_n;
    logic host_reset_n;
    logic host_power_tx;
    // open-drain data line drivers, enables low active
    logic host_data_o;
    logic host_data_oe_n;
    logic dev_data_o;
    logic dev_data_oe_n;
    // module open-drain outputs
    logic dev_irq_o;
    logic dev_irq_oe_n;
    logic dev_present_o;
    logic dev_present_oe_n;
    // resolved pin levels
    logic module_select_n;
    logic module_reset_n;
    logic power_or_tx_off_input;
    logic mgmt_data;
    logic irq_or_rx_loss_output_n;
    logic module_present_n;

    // undriven inputs are pulled high inside the module
    assign module_select_n = host_drive_en ? host_select_n : 1'b1;
    assign module_reset_n = host_drive_en ? host_reset_n : 1'b1;
    assign power_or_tx_off_input =
        host_drive_en ? host_power_tx : 1'b1;
    // wired and with the host pull-up
    assign mgmt_data = (host_data_oe_n | host_data_o) &
        (dev_data_oe_n | dev_data_o);
    assign irq_or_rx_loss_output_n = dev_irq_oe_n | dev_irq_o;
    assign module_present_n = dev_present_oe_n | dev_present_o;

    modport device_end (
        input mgmt_clock,
        input module_select_n,
        input module_reset_n,
        input power_or_tx_off_input,
        input mgmt_data,
        output dev_data_o,
        output dev_data_oe_n,
        output dev_irq_o,
        output dev_irq_oe_n,
        output dev_present_o,
        output dev_present_oe_n
    );
    modport host_end (
        input mgmt_clock,
        input mgmt_data,
        input irq_or_rx_loss_output_n,
        input module_present_n,
        output host_drive_en,
        output host_select_n,
        output host_reset_n,
        output host_power_tx,
        output host_data_o,
        output host_data_oe_n
    );
endinterface

/* pkg/msbc_pkg.sv */
// shared constants and types for the sideband control link
package msbc_pkg;
    // clock periods, ns
    localparam int CLOCK_NS = 100;
    localparam int LINK_NS = 6;
    // host waits after select and deselect, ns
    localparam int SEL_ASSERT_NS = 2000;
    localparam int SEL_DEASSERT_NS = 2000;
    // least low time of the reset pin, ns
    localparam int RESET_MIN_NS = 10000;
    // least times round up to whole cycles
    localparam logic [7:0] SEL_ASSERT_CYC =
        8'((SEL_ASSERT_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [7:0] SEL_DEASSERT_CYC =
        8'((SEL_DEASSERT_NS + CLOCK_NS - 1) / CLOCK_NS);
    // host holds reset one cycle beyond the least time
    localparam logic [7:0] HOST_RESET_CYC =
        8'((RESET_MIN_NS + CLOCK_NS - 1) / CLOCK_NS + 1);
    // module counts the low time on the link clock
    localparam logic [11:0] RESET_MIN_CYC =
        12'((RESET_MIN_NS + LINK_NS - 1) / LINK_NS);
    // management register addresses
    localparam logic [1:0] REG_FLAGS = 2'h0;
    localparam logic [1:0] REG_CONFIG = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_IDENT = 2'h3;
    // field positions
    localparam int FLAG_STATE_BIT = 0;
    localparam int FLAG_FAULT_BIT = 1;
    localparam int FLAG_CRIT_BIT = 2;
    localparam int CFG_TX_OFF_BIT = 0;
    localparam int CFG_RX_LOSS_BIT = 1;
    localparam int STS_RX_LOSS_BIT = 0;
    localparam int STS_INPUT_BIT = 1;
    localparam int STS_RESET_BIT = 2;
    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // identity byte, value arbitrary
    localparam logic [7:0] IDENT_VALUE = 8'h5a;
    // frame layout: header bit one means read
    localparam logic RW_READ = 1'b1;
    localparam logic [2:0] HDR_LAST = 3'h2;
    localparam logic [2:0] DATA_LAST = 3'h7;
    // frame states of the module end
    typedef enum logic [1:0] {DEV_IDLE, DEV_HDR, DEV_ACK, DEV_DATA}
        msbc_dev_state_t;
    // command states of the host end
    typedef enum logic [2:0] {H_IDLE, H_RESET, H_SELECT, H_XFER,
        H_DESELECT} msbc_host_state_t;
    // serial states of the host end
    typedef enum logic [2:0] {L_IDLE, L_HDR, L_TURN, L_ACK, L_DATA}
        msbc_ser_state_t;
endpackage

/* rtl/msbc_device.sv */
// module end: sideband pins, dual-mode pins and management slave
`timescale 1ns/10ps
// Notes on behaviour
// - answer management only while selected
// - deselected module never acks nor drives
// - select floats high when undriven
// - host waits deassert time after deselect
// - host waits assert time before frame
// - waits of different modules may overlap
// - reset pin floats high when undriven
// - long reset low restores all defaults
// - dual input active high, floats high
// - after reset dual input means low power
// - input remap by write, refused during reset
// - present pin tied low inside module
// - irq pin open-drain, low active only
// - after reset dual output means interrupt
// - events set flags, drive irq low
// - host reads flags to find source
// - irq released once all flags read
// - output remap by write, refused during reset
// - mode switch keeps level when no flags and no signal loss
// - management over clock and data lines
module msbc_device
    import msbc_pkg::*;
(
    input wire logic rst,
    msbc_link_if.device_end link,
    input wire logic event_state_change,
    input wire logic event_fault,
    input wire logic event_critical,
    input wire logic rx_loss,
    output logic low_power_request,
    output logic transmit_off_request,
    output logic module_in_reset,
    output logic [7:0] config_bits
);
    // all module state, clocked by the link clock
    typedef struct packed {
        logic sel_s1;      // select synchroniser
        logic sel_s2;
        logic rst_s1;      // reset pin synchroniser
        logic rst_s2;
        logic pin_s1;      // dual input synchroniser
        logic pin_s2;
        logic [11:0] hold_cnt; // reset low time
        logic in_reset;    // full reset in force
        logic cfg_tx_off;  // input acts as transmit off
        logic cfg_rx_loss; // output acts as signal loss
        logic [2:0] flags; // sticky interrupt flags
        logic [2:0] ev_s1; // event synchroniser
        logic [2:0] ev_s2;
        logic loss_s1;     // signal loss synchroniser
        logic loss_s2;
        msbc_dev_state_t fsm;
        logic [2:0] cnt;   // bit counter in a frame
        logic [2:0] hdr;   // read flag and address
        logic [7:0] shreg; // data shifter
        logic data_o;      // data line drive value
        logic data_oe_n;   // data line enable, low drives
        logic irq_drive;   // pull the dual output low
        logic lp_req;
        logic tx_off;
    } msbc_dev_regs_t;

    // pins come up as if undriven: high
    localparam msbc_dev_regs_t DEV_RESET = '{sel_s1: 1'b1,
        sel_s2: 1'b1, rst_s1: 1'b1, rst_s2: 1'b1, pin_s1: 1'b1,
        pin_s2: 1'b1, fsm: DEV_IDLE, data_o: 1'b1, data_oe_n: 1'b1,
        lp_req: 1'b1, default: '0};

    msbc_dev_regs_t r;     // registered state
    msbc_dev_regs_t next_r; // next state
    logic [2:0] events;    // this cycle's flag sources
    logic [7:0] rd_byte;   // byte a read would return
    logic [7:0] wr_byte;   // byte a write holds at its last bit

    assign events[FLAG_STATE_BIT] = event_state_change;
    assign events[FLAG_FAULT_BIT] = event_fault;
    assign events[FLAG_CRIT_BIT] = event_critical;

    // register read decode
    function automatic logic [7:0] msbc_read_reg(
        input logic [1:0] addr,
        input msbc_dev_regs_t st,
        input logic loss
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr == REG_FLAGS)
            v[2:0] = st.flags;
        else if (addr == REG_CONFIG)
        begin
            v[CFG_TX_OFF_BIT] = st.cfg_tx_off;
            v[CFG_RX_LOSS_BIT] = st.cfg_rx_loss;
        end
        else if (addr == REG_STATUS)
        begin
            v[STS_RX_LOSS_BIT] = loss;
            v[STS_INPUT_BIT] = st.pin_s2;
            v[STS_RESET_BIT] = ~st.rst_s2;
        end
        else
            v = IDENT_VALUE;
        return v;
    endfunction

    assign rd_byte = msbc_read_reg(r.hdr[1:0], r, r.loss_s2);
    // last bit is still on the line, the rest sits in the shifter
    assign wr_byte = {r.shreg[6:0], link.mgmt_data};

    // pins, reset timing, flags and the management slave
    always_comb
    begin
        next_r = r;
        // two flip-flops before any logic looks at select, reset or the dual input
        next_r.sel_s1 = link.module_select_n;
        next_r.sel_s2 = r.sel_s1;
        next_r.rst_s1 = link.module_reset_n;
        next_r.rst_s2 = r.rst_s1;
        next_r.pin_s1 = link.power_or_tx_off_input;
        next_r.pin_s2 = r.pin_s1;
        // user side sources may come from another clock
        next_r.ev_s1 = events;
        next_r.ev_s2 = r.ev_s1;
        next_r.loss_s1 = rx_loss;
        next_r.loss_s2 = r.loss_s1;

        // a short low glitch on reset is ignored
        if (r.rst_s2)
        begin
            next_r.hold_cnt = 12'h000;
            next_r.in_reset = 1'b0;
        end
        else if (r.hold_cnt != RESET_MIN_CYC)
            next_r.hold_cnt = r.hold_cnt + 12'h001;
        else
            next_r.in_reset = 1'b1;

        // flags are sticky; a new event beats a read clear
        next_r.flags = r.flags | r.ev_s2;

        case (r.fsm)
            DEV_IDLE:
                // start bit counts only while selected
                if (!r.sel_s2 && !link.mgmt_data)
                begin
                    next_r.cnt = 3'h0;
                    next_r.fsm = DEV_HDR;
                end
            DEV_HDR:
            begin
                next_r.hdr = {r.hdr[1:0], link.mgmt_data};
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == HDR_LAST)
                begin
                    // acknowledge by pulling the line low
                    next_r.data_o = 1'b0;
                    next_r.data_oe_n = 1'b0;
                    next_r.fsm = DEV_ACK;
                end
            end
            DEV_ACK:
            begin
                next_r.cnt = 3'h0;
                next_r.fsm = DEV_DATA;
                if (r.hdr[2] == RW_READ)
                begin
                    next_r.data_o = rd_byte[7];
                    next_r.shreg = {rd_byte[6:0], 1'b0};
                    // flags go when a read of them is acknowledged, before the byte shifts out
                    if (r.hdr[1:0] == REG_FLAGS)
                        next_r.flags = r.ev_s2;
                end
                else
                begin
                    next_r.data_o = 1'b1;
                    next_r.data_oe_n = 1'b1;
                end
            end
            DEV_DATA:
            begin
                next_r.cnt = r.cnt + 3'h1;
                if (r.hdr[2] == RW_READ)
                begin
                    next_r.data_o = r.shreg[7];
                    next_r.shreg = {r.shreg[6:0], 1'b0};
                end
                else
                    next_r.shreg = {r.shreg[6:0], link.mgmt_data};
                if (r.cnt == DATA_LAST)
                begin
                    next_r.data_o = 1'b1;
                    next_r.data_oe_n = 1'b1;
                    next_r.fsm = DEV_IDLE;
                    // pin remaps are refused while reset is low
                    if (r.hdr[2] != RW_READ && r.hdr[1:0] == REG_CONFIG
                        && r.rst_s2 && !r.in_reset)
                    begin
                        next_r.cfg_tx_off = wr_byte[CFG_TX_OFF_BIT];
                        next_r.cfg_rx_loss = wr_byte[CFG_RX_LOSS_BIT];
                    end
                end
            end
            default:
                next_r.fsm = DEV_IDLE;
        endcase

        // deselect mid-frame drops the frame and frees the line
        if (r.sel_s2 && r.fsm != DEV_IDLE)
        begin
            next_r.fsm = DEV_IDLE;
            next_r.data_o = 1'b1;
            next_r.data_oe_n = 1'b1;
        end

        // full reset: defaults for every user setting
        if (r.in_reset)
        begin
            next_r.cfg_tx_off = CONFIG_RESET[CFG_TX_OFF_BIT];
            next_r.cfg_rx_loss = CONFIG_RESET[CFG_RX_LOSS_BIT];
            next_r.flags = 3'h0;
            next_r.fsm = DEV_IDLE;
            next_r.data_o = 1'b1;
            next_r.data_oe_n = 1'b1;
        end

        // dual input: low power unless remapped
        next_r.lp_req = r.pin_s2 & ~next_r.cfg_tx_off;
        next_r.tx_off = r.pin_s2 & next_r.cfg_tx_off;

        // dual output: flags by default, else signal loss;
        // with no flags and no loss the level stays high
        next_r.irq_drive = next_r.cfg_rx_loss ? r.loss_s2
            : (next_r.flags != 3'h0);
    end

    // state register
    always_ff @(posedge link.mgmt_clock)
    begin
        if (rst)
            r <= DEV_RESET;
        else
            r <= next_r;
    end

    // open-drain outputs only ever pull low
    assign link.dev_irq_o = 1'b0;
    assign link.dev_irq_oe_n = ~r.irq_drive;
    // present is held low while the module sits in the slot
    assign link.dev_present_o = 1'b0;
    assign link.dev_present_oe_n = 1'b0;
    assign link.dev_data_o = r.data_o;
    assign link.dev_data_oe_n = r.data_oe_n;

    // user side
    assign low_power_request = r.lp_req;
    assign transmit_off_request = r.tx_off;
    assign module_in_reset = r.in_reset;
    assign config_bits = {6'h00, r.cfg_rx_loss, r.cfg_tx_off};
endmodule

/* rtl/msbc_host.sv */
// host board end: select timing, reset pulse and serial master
`timescale 1ns/10ps
module msbc_host
    import msbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    msbc_link_if.host_end link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [1:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic resp_valid,
    output logic [7:0] resp_rdata,
    output logic resp_nack,
    input wire logic reset_request,
    input wire logic power_or_tx_off_level,
    output logic irq_seen_n,
    output logic present_seen_n
);
    // state of the command side, on clock
    typedef struct packed {
        msbc_host_state_t fsm;
        logic [7:0] wait_cnt;
        logic drive_en;
        logic sel_n;
        logic reset_n;
        logic power;
        logic req_tgl;
        logic write;
        logic [1:0] addr;
        logic [7:0] wdata;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic irq_s1;
        logic irq_s2;
        logic prs_s1;
        logic prs_s2;
        logic resp_valid;
        logic [7:0] resp_rdata;
        logic resp_nack;
    } msbc_host_regs_t;
    // state of the serial side, on the link clock
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        msbc_ser_state_t fsm;
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic data_o;
        logic data_oe_n;
        logic done_tgl;
        logic [7:0] rdata;
        logic nack;
    } msbc_ser_regs_t;

    localparam msbc_host_regs_t HOST_RESET = '{fsm: H_IDLE,
        reset_n: 1'b1, sel_n: 1'b1, power: 1'b1, irq_s1: 1'b1,
        irq_s2: 1'b1, prs_s1: 1'b1, prs_s2: 1'b1, default: '0};
    localparam msbc_ser_regs_t SER_RESET = '{fsm: L_IDLE,
        data_o: 1'b1, data_oe_n: 1'b1, default: '0};

    msbc_host_regs_t h;
    msbc_host_regs_t next_h;
    msbc_ser_regs_t s;
    msbc_ser_regs_t next_s;

    // command side: select waits and handshake to the serial side
    always_comb
    begin
        next_h = h;
        next_h.drive_en = 1'b1;
        next_h.power = power_or_tx_off_level;
        next_h.resp_valid = 1'b0;
        // pins and the done toggle pass two flip-flops
        next_h.ack_s1 = s.done_tgl;
        next_h.ack_s2 = h.ack_s1;
        next_h.irq_s1 = link.irq_or_rx_loss_output_n;
        next_h.irq_s2 = h.irq_s1;
        next_h.prs_s1 = link.module_present_n;
        next_h.prs_s2 = h.prs_s1;
        case (h.fsm)
            H_IDLE:
                if (reset_request)
                begin
                    // pulse outlasts the module's least low time
                    next_h.reset_n = 1'b0;
                    next_h.wait_cnt = HOST_RESET_CYC - 8'h01;
                    next_h.fsm = H_RESET;
                end
                else if (cmd_valid)
                begin
                    next_h.write = cmd_write;
                    next_h.addr = cmd_addr;
                    next_h.wdata = cmd_wdata;
                    next_h.sel_n = 1'b0;
                    next_h.wait_cnt = SEL_ASSERT_CYC - 8'h01;
                    next_h.fsm = H_SELECT;
                end
            H_RESET:
                if (h.wait_cnt == 8'h00)
                begin
                    next_h.reset_n = 1'b1;
                    next_h.fsm = H_IDLE;
                end
                else
                    next_h.wait_cnt = h.wait_cnt - 8'h01;
            H_SELECT:
                // no frame before the assert time is over
                if (h.wait_cnt == 8'h00)
                begin
                    next_h.req_tgl = ~h.req_tgl;
                    next_h.fsm = H_XFER;
                end
                else
                    next_h.wait_cnt = h.wait_cnt - 8'h01;
            H_XFER:
                if (h.ack_s2 != h.ack_seen)
                begin
                    // serial words are stable once done toggles
                    next_h.ack_seen = h.ack_s2;
                    next_h.resp_valid = 1'b1;
                    next_h.resp_rdata = s.rdata;
                    next_h.resp_nack = s.nack;
                    next_h.sel_n = 1'b1;
                    next_h.wait_cnt = SEL_DEASSERT_CYC - 8'h01;
                    next_h.fsm = H_DESELECT;
                end
            H_DESELECT:
                // one module here, so waits never overlap
                if (h.wait_cnt == 8'h00)
                    next_h.fsm = H_IDLE;
                else
                    next_h.wait_cnt = h.wait_cnt - 8'h01;
            default:
                next_h.fsm = H_IDLE;
        endcase
    end

    // command side registers
    always_ff @(posedge clock)
    begin
        if (rst)
            h <= HOST_RESET;
        else
            h <= next_h;
    end

    // serial side: start, header, turn, ack, eight data bits
    always_comb
    begin
        next_s = s;
        next_s.req_s1 = h.req_tgl;
        next_s.req_s2 = s.req_s1;
        case (s.fsm)
            L_IDLE:
                if (s.req_s2 != s.req_seen)
                begin
                    // start bit, then header on the data line
                    next_s.req_seen = s.req_s2;
                    next_s.data_o = 1'b0;
                    next_s.data_oe_n = 1'b0;
                    next_s.shreg = {5'h00, ~h.write, h.addr};
                    next_s.cnt = 3'h0;
                    next_s.fsm = L_HDR;
                end
            L_HDR:
            begin
                next_s.data_o = s.shreg[2];
                next_s.shreg = {s.shreg[6:0], 1'b0};
                next_s.cnt = s.cnt + 3'h1;
                if (s.cnt == HDR_LAST)
                    next_s.fsm = L_TURN;
            end
            L_TURN:
            begin
                // hand the line over for the ack slot
                next_s.data_o = 1'b1;
                next_s.data_oe_n = 1'b1;
                next_s.fsm = L_ACK;
            end
            L_ACK:
                if (link.mgmt_data)
                begin
                    // nobody answered
                    next_s.nack = 1'b1;
                    next_s.done_tgl = ~s.done_tgl;
                    next_s.fsm = L_IDLE;
                end
                else
                begin
                    next_s.cnt = 3'h0;
                    next_s.fsm = L_DATA;
                    if (h.write)
                    begin
                        next_s.data_o = h.wdata[7];
                        next_s.data_oe_n = 1'b0;
                        next_s.shreg = {h.wdata[6:0], 1'b0};
                    end
                end
            L_DATA:
            begin
                next_s.cnt = s.cnt + 3'h1;
                if (h.write)
                begin
                    next_s.data_o = s.shreg[7];
                    next_s.shreg = {s.shreg[6:0], 1'b0};
                end
                else
                    next_s.shreg = {s.shreg[6:0], link.mgmt_data};
                if (s.cnt == DATA_LAST)
                begin
                    next_s.data_o = 1'b1;
                    next_s.data_oe_n = 1'b1;
                    next_s.rdata = {s.shreg[6:0], link.mgmt_data};
                    next_s.nack = 1'b0;
                    next_s.done_tgl = ~s.done_tgl;
                    next_s.fsm = L_IDLE;
                end
            end
            default:
                next_s.fsm = L_IDLE;
        endcase
        // reset reaches this side through two flip-flops
        if (s.rst_s2)
            next_s = SER_RESET;
        next_s.rst_s1 = rst;
        next_s.rst_s2 = s.rst_s1;
    end

    // serial side registers
    always_ff @(posedge link.mgmt_clock)
    begin
        s <= next_s;
    end

    // pins and user outputs
    assign link.host_drive_en = h.drive_en;
    assign link.host_select_n = h.sel_n;
    assign link.host_reset_n = h.reset_n;
    assign link.host_power_tx = h.power;
    assign link.host_data_o = s.data_o;
    assign link.host_data_oe_n = s.data_oe_n;
    assign cmd_ready = (h.fsm == H_IDLE) && !reset_request;
    assign resp_valid = h.resp_valid;
    assign resp_rdata = h.resp_rdata;
    assign resp_nack = h.resp_nack;
    assign irq_seen_n = h.irq_s2;
    assign present_seen_n = h.prs_s2;
endmodule

/* verification/msbc_asserts.sv */
// checker on the connector pins of the sideband link
`timescale 1ns/10ps
module msbc_asserts (
    input wire logic mgmt_clock,
    input wire logic rst,
    input wire logic module_select_n,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic mgmt_data,
    input wire logic dev_irq_o,
    input wire logic dev_irq_oe_n,
    input wire logic module_present_n
);
    default clocking @(posedge mgmt_clock); endclocking
    default disable iff (rst);
    // select passes two sync flops, so allow a few cycles
    a_deselect_quiet: assert property (
        module_select_n[*5] |-> dev_data_oe_n) else $error("unselected drive");
    a_ack_needs_select: assert property (
        !dev_data_oe_n |-> $past(!module_select_n, 4)) else $error("no sel");
    a_start_after_select: assert property (
        $fell(mgmt_data) && !host_data_oe_n |-> $past(!module_select_n, 2))
        else $error("start too soon");
    a_deselect_wait: assert property (
        $rose(module_select_n) |-> host_data_oe_n[*8]) else $error("no wait");
    a_present_tied: assert property (
        module_present_n == 1'h0) else $error("present high");
    a_irq_pull_only: assert property (
        !dev_irq_oe_n |-> !dev_irq_o) else $error("irq driven high");
    a_irq_after_reset: assert property (
        $fell(rst) |-> dev_irq_oe_n) else $error("irq low after reset");
    a_one_data_driver: assert property (
        !dev_data_oe_n |-> host_data_oe_n) else $error("two data drivers");
    // main scenarios seen
    c_irq: cover property (!dev_irq_oe_n);
    c_ack: cover property (!dev_data_oe_n);
    c_desel: cover property ($rose(module_select_n));
endmodule

/* verification/msbc_tb_top.sv */
// bench joining host and module ends over the link
`timescale 1ns/10ps
module msbc_tb_top import msbc_pkg::*;;
    logic clock = 1'h0, mgmt_clock = 1'h0, rst = 1'h1;
    logic cmd_valid = 1'h0, cmd_ready, cmd_write = 1'h0, resp_valid, nack;
    logic [1:0] cmd_addr = 2'h0;
    logic [7:0] cmd_wdata = 8'h00, resp_rdata, config_bits, rd;
    logic reset_request = 1'h0, irq_seen_n, present_seen_n;
    logic [2:0] ev = 3'h0;
    logic rx_loss = 1'h0, lp_req, tx_off, in_reset, pwr = 1'h1;
    int err_total = 0, check_count = 0, cyc = 0;
    always #50 clock = ~clock;
    // half periods keep the rising edges of the two apart
    always #3 mgmt_clock = ~mgmt_clock;
    msbc_link_if msbc_link_if_i (.mgmt_clock(mgmt_clock));
    msbc_host msbc_host_i (.clock(clock), .rst(rst), .link(msbc_link_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .resp_nack(nack), .irq_seen_n(irq_seen_n),
        .reset_request(reset_request), .power_or_tx_off_level(pwr),
        .present_seen_n(present_seen_n));
    msbc_device msbc_device_i (.rst(rst), .link(msbc_link_if_i),
        .event_state_change(ev[0]), .event_fault(ev[1]),
        .event_critical(ev[2]), .rx_loss(rx_loss), .config_bits(config_bits),
        .low_power_request(lp_req), .transmit_off_request(tx_off),
        .module_in_reset(in_reset));
    msbc_asserts msbc_asserts_i (.mgmt_clock(mgmt_clock), .rst(rst),
        .module_select_n(msbc_link_if_i.module_select_n),
        .host_data_oe_n(msbc_link_if_i.host_data_oe_n),
        .dev_data_oe_n(msbc_link_if_i.dev_data_oe_n),
        .mgmt_data(msbc_link_if_i.mgmt_data),
        .dev_irq_o(msbc_link_if_i.dev_irq_o),
        .dev_irq_oe_n(msbc_link_if_i.dev_irq_oe_n),
        .module_present_n(msbc_link_if_i.module_present_n));
    task automatic chk(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // hang is cut by the cycle ceiling below
    task automatic wait_hi(ref logic s);
        do @(negedge clock); while (s !== 1'h1);
    endtask
    // one command, held until taken, answer read at its pulse
    task automatic access(input logic w, input logic [1:0] a,
        input logic [7:0] d);
        @(posedge clock);
        cmd_valid <= 1'h1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        wait_hi(cmd_ready);
        @(posedge clock);
        cmd_valid <= 1'h0;
        wait_hi(resp_valid);
        rd = resp_rdata;
        chk({7'h0, nack}, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        repeat (4) @(posedge clock);
        access(1'h0, REG_CONFIG, 8'h00);
        chk(rd, CONFIG_RESET);
        chk({6'h0, lp_req, tx_off}, 8'h02);
        chk({6'h0, present_seen_n, irq_seen_n}, 8'h01);
        access(1'h0, REG_IDENT, 8'h00);
        chk(rd, IDENT_VALUE);
        $display("defaults done");
        // each source pulls the pin until its flag is read
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            ev <= 3'h1 << i;
            @(posedge clock);
            ev <= 3'h0;
            repeat (4) @(negedge clock);
            chk({7'h0, irq_seen_n}, 8'h00);
            access(1'h0, REG_FLAGS, 8'h00);
            chk(rd, 8'h01 << i);
            repeat (4) @(negedge clock);
            chk({7'h0, irq_seen_n}, 8'h01);
        end
        $display("irq done");
        access(1'h1, REG_CONFIG, 8'h03);
        repeat (4) @(negedge clock);
        chk(config_bits, 8'h03);
        chk({6'h0, lp_req, tx_off}, 8'h01);
        chk({7'h0, irq_seen_n}, 8'h01);
        @(posedge clock);
        pwr <= 1'h0;
        repeat (4) @(negedge clock);
        chk({6'h0, lp_req, tx_off}, 8'h00);
        @(posedge clock);
        pwr <= 1'h1;
        rx_loss <= 1'h1;
        repeat (4) @(negedge clock);
        chk({7'h0, irq_seen_n}, 8'h00);
        access(1'h0, REG_STATUS, 8'h00);
        chk(rd, 8'h03);
        $display("remap done");
        // host must be idle again before it takes the reset
        repeat (30) @(posedge clock);
        reset_request <= 1'h1;
        @(posedge clock);
        reset_request <= 1'h0;
        repeat (130) @(negedge clock);
        chk(config_bits, CONFIG_RESET);
        chk({5'h0, in_reset, lp_req, tx_off}, 8'h02);
        chk({7'h0, irq_seen_n}, 8'h01);
        $display("reset done");
        report_and_stop();
    end
endmodule
